//--- icpp_pkg.sv
// icpp_pkg: constants for the indexed configuration port pair block
// assumes 8-bit I/O data and a 16-bit I/O port address from the host
package icpp_pkg;
    // ========================================
    // widths
    localparam int ICPP_AW = 16; // i/o address width
    localparam int ICPP_DW = 8; // i/o data width
    // ========================================
    // i/o port offsets
    localparam logic [15:0] ICPP_CFG_INDEX_PORT = 16'h0022; // normal window index
    localparam logic [15:0] ICPP_CFG_DATA_PORT = 16'h0023; // normal window data
    localparam logic [15:0] ICPP_SYS_INDEX_PORT = 16'h0026; // system management index
    localparam logic [15:0] ICPP_SYS_DATA_PORT = 16'h0027; // system management data
    localparam logic [15:0] ICPP_KBD_DATA_PORT = 16'h0060; // keyboard data port
    // ========================================
    // keyboard data port fields
    localparam int ICPP_KBD_RESET_BIT = 0; // low requests fast processor reset
    localparam int ICPP_KBD_A20_BIT = 1; // high opens address line 20
    // ========================================
    // reset values
    localparam logic [7:0] ICPP_CFG_DEFAULT = 8'h00; // power-on config value
    localparam logic [7:0] ICPP_INDEX_RESET = 8'h00; // index after reset
    localparam logic [7:0] ICPP_KBD_RESET = 8'h01; // a20 closed, no reset
    localparam logic [7:0] ICPP_IGNORED_READ = 8'hFF; // answer to an ignored read
    localparam logic [7:0] ICPP_RDATA_RESET = 8'h00; // read data after reset
endpackage : icpp_pkg

//--- icpp_port_pair.sv
// icpp_port_pair: two index/data configuration windows plus keyboard data port
// assumes single-cycle i/o read and write strobes, never both in one cycle
//
// Operation
// [R1] reset loads power-on defaults into config registers
// [R2] port 22 write latches normal window index
// [R3] port 23 reaches register chosen by port 22
// [R4] repeat port 23 access without index write ignored
// [R5] software leaves undefined indexes and reserved bits alone
// [R6] port 26 index held apart from port 22
// [R7] port 26 index selects register for port 27
// [R8] port 27 reaches register chosen by port 26
// [R9] repeat port 27 access without index write ignored
// [R10] each window keeps its own accessed flag
// [R11] port 60 controls a20 gating and fast reset
// [R12] index write clears flag, one data access follows
`timescale 1ns/100ps
`default_nettype none
module icpp_port_pair
    import icpp_pkg::*;
#(
    parameter int ICPP_DEPTH = 256 // number of indexed config registers
) (
    input wire logic clk_sys, // 50 MHz system clock
    input wire logic resetn, // async reset, active low
    input wire logic [icpp_pkg::ICPP_AW-1:0] io_addr, // i/o port address
    input wire logic io_wr, // one-cycle write strobe
    input wire logic io_rd, // one-cycle read strobe
    input wire logic [icpp_pkg::ICPP_DW-1:0] io_wdata, // write data
    output logic [icpp_pkg::ICPP_DW-1:0] io_rdata, // read data, registered
    output logic io_rdata_valid, // read answer pulse
    output logic addr_line20_gate, // high lets address line 20 through
    output logic fast_reset // one-cycle processor reset pulse
);
    import icpp_pkg::*;

    // ========================================
    // storage
    logic [7:0] cfg_mem [ICPP_DEPTH]; // indexed config registers
    logic [7:0] cfg_index; // normal window index
    logic [7:0] sys_index; // system management window index
    logic cfg_accessed; // normal window used since index write
    logic sys_accessed; // system window used since index write
    logic [7:0] kbd_port; // last value written to keyboard port

    // ========================================
    // port decode
    logic hit_cfg_index; // normal index port
    logic hit_cfg_data; // normal data port
    logic hit_sys_index; // system index port
    logic hit_sys_data; // system data port
    logic hit_kbd; // keyboard data port
    logic cfg_go; // normal data access takes effect
    logic sys_go; // system data access takes effect
    logic [7:0] sel_cfg; // register under normal index
    logic [7:0] sel_sys; // register under system index

    assign hit_cfg_index = (io_addr == ICPP_CFG_INDEX_PORT);
    assign hit_cfg_data = (io_addr == ICPP_CFG_DATA_PORT);
    assign hit_sys_index = (io_addr == ICPP_SYS_INDEX_PORT);
    assign hit_sys_data = (io_addr == ICPP_SYS_DATA_PORT);
    assign hit_kbd = (io_addr == ICPP_KBD_DATA_PORT);
    // [R4] [R9] one-shot gating
    assign cfg_go = hit_cfg_data && (io_wr || io_rd) && !cfg_accessed;
    assign sys_go = hit_sys_data && (io_wr || io_rd) && !sys_accessed;
    // [R3] [R7] [R8] index selects register
    assign sel_cfg = cfg_mem[cfg_index];
    assign sel_sys = cfg_mem[sys_index];

    // ========================================
    // index latches
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cfg_index <= ICPP_INDEX_RESET;
            sys_index <= ICPP_INDEX_RESET;
        end else begin
            // [R2] latch normal index
            if (io_wr && hit_cfg_index) begin
                cfg_index <= io_wdata;
            end
            // [R6] separate system index
            if (io_wr && hit_sys_index) begin
                sys_index <= io_wdata;
            end
        end
    end

    // ========================================
    // accessed flags, one per window
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cfg_accessed <= 1'b0;
            sys_accessed <= 1'b0;
        end else begin
            // [R10] [R12] normal window flag
            if (io_wr && hit_cfg_index) begin
                cfg_accessed <= 1'b0;
            end else if (cfg_go) begin
                cfg_accessed <= 1'b1;
            end
            // [R10] [R12] system window flag
            if (io_wr && hit_sys_index) begin
                sys_accessed <= 1'b0;
            end else if (sys_go) begin
                sys_accessed <= 1'b1;
            end
        end
    end

    // ========================================
    // config register array
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            // [R1] power-on defaults
            for (int i = 0; i < ICPP_DEPTH; i++) begin
                cfg_mem[i] <= ICPP_CFG_DEFAULT;
            end
        end else begin
            // [R3] normal window write
            if (io_wr && cfg_go) begin
                cfg_mem[cfg_index] <= io_wdata;
            end else if (io_wr && sys_go) begin
                // [R8] system window write
                cfg_mem[sys_index] <= io_wdata;
            end
        end
    end

    // ========================================
    // keyboard data port
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            kbd_port <= ICPP_KBD_RESET;
            addr_line20_gate <= ICPP_KBD_RESET[ICPP_KBD_A20_BIT];
            fast_reset <= 1'b0;
        end else begin
            // [R11] gate and reset control
            if (io_wr && hit_kbd) begin
                kbd_port <= io_wdata;
                addr_line20_gate <= io_wdata[ICPP_KBD_A20_BIT];
                fast_reset <= !io_wdata[ICPP_KBD_RESET_BIT];
            end else begin
                fast_reset <= 1'b0;
            end
        end
    end

    // ========================================
    // read answer
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            io_rdata <= ICPP_RDATA_RESET;
            io_rdata_valid <= 1'b0;
        end else begin
            io_rdata_valid <= io_rd && (hit_cfg_data || hit_sys_data || hit_kbd);
            // only reads that get an answer touch the data
            if (io_rd && cfg_go) begin
                // [R3] normal window read
                io_rdata <= sel_cfg;
            end else if (io_rd && sys_go) begin
                // [R8] system window read
                io_rdata <= sel_sys;
            end else if (io_rd && hit_kbd) begin
                // [R11] keyboard port readback
                io_rdata <= kbd_port;
            end else if (io_rd && (hit_cfg_data || hit_sys_data)) begin
                // [R4] [R9] ignored read floats high
                io_rdata <= ICPP_IGNORED_READ;
            end else begin
                // index, unmapped or no read: keep old data
                io_rdata <= io_rdata;
            end
        end
    end

    // ========================================
    // assertions
    // [R1] flops sit at reset values
    chk_reset_values: assert property (@(posedge clk_sys) // [R1]
        !resetn ##1 !resetn |-> !cfg_accessed && !sys_accessed && !fast_reset && !io_rdata_valid
        && cfg_index == ICPP_INDEX_RESET && sys_index == ICPP_INDEX_RESET)
        else $error("state not at reset values");

    // [R2] index latch
    chk_cfg_index_latch: assert property (@(posedge clk_sys) disable iff (!resetn) // [R2]
        io_wr && hit_cfg_index |=> cfg_index == $past(io_wdata) && !cfg_accessed)
        else $error("normal index not latched");

    // [R2] index kept between writes
    chk_cfg_index_hold: assert property (@(posedge clk_sys) disable iff (!resetn) // [R2]
        !(io_wr && hit_cfg_index) |=> $stable(cfg_index))
        else $error("normal index changed without write");

    // [R2] index port read gives no answer
    chk_index_read_quiet: assert property (@(posedge clk_sys) disable iff (!resetn) // [R2]
        io_rd && (hit_cfg_index || hit_sys_index) |=> !io_rdata_valid && $stable(io_rdata))
        else $error("index port read answered");

    // [R3] first write lands
    chk_cfg_write_once: assert property (@(posedge clk_sys) disable iff (!resetn) // [R3]
        io_wr && hit_cfg_data && !cfg_accessed |=> sel_cfg == $past(io_wdata))
        else $error("normal data write lost");

    // [R3] read returns selected register
    chk_cfg_read_data: assert property (@(posedge clk_sys) disable iff (!resetn) // [R3]
        io_rd && hit_cfg_data && !cfg_accessed |=> io_rdata == $past(sel_cfg)
        ##1 !io_rdata_valid || $past(io_rd))
        else $error("normal read returned wrong data");

    // [R3] answer only after a read
    chk_read_answer: assert property (@(posedge clk_sys) disable iff (!resetn) // [R3]
        io_rdata_valid |-> $past(io_rd))
        else $error("read answer without read");

    // [R4] second write dropped
    chk_cfg_repeat_drop: assert property (@(posedge clk_sys) disable iff (!resetn) // [R4]
        io_wr && hit_cfg_data && cfg_accessed |=> sel_cfg == $past(sel_cfg))
        else $error("repeat normal write took effect");

    // [R4] ignored read answer
    chk_cfg_repeat_read: assert property (@(posedge clk_sys) disable iff (!resetn) // [R4]
        io_rd && hit_cfg_data && cfg_accessed
        |=> io_rdata_valid && io_rdata == ICPP_IGNORED_READ)
        else $error("repeat normal read not ignored");

    // [R6] separate index storage
    chk_sys_index_apart: assert property (@(posedge clk_sys) disable iff (!resetn) // [R6]
        io_wr && hit_sys_index |=> sys_index == $past(io_wdata) && $stable(cfg_index))
        else $error("system index not kept apart");

    // [R6] system index kept between writes
    chk_sys_index_hold: assert property (@(posedge clk_sys) disable iff (!resetn) // [R6]
        !(io_wr && hit_sys_index) |=> $stable(sys_index))
        else $error("system index changed without write");

    // [R7] system read uses system index
    chk_sys_read_data: assert property (@(posedge clk_sys) disable iff (!resetn) // [R7]
        io_rd && hit_sys_data && !sys_accessed
        |=> io_rdata_valid && io_rdata == $past(sel_sys))
        else $error("system read returned wrong data");

    // [R8] system write lands
    chk_sys_write_once: assert property (@(posedge clk_sys) disable iff (!resetn) // [R8]
        io_wr && hit_sys_data && !sys_accessed |=> sel_sys == $past(io_wdata))
        else $error("system data write lost");

    // [R9] second system write dropped
    chk_sys_repeat_drop: assert property (@(posedge clk_sys) disable iff (!resetn) // [R9]
        io_wr && hit_sys_data && sys_accessed |=> sel_sys == $past(sel_sys))
        else $error("repeat system write took effect");

    // [R9] ignored system read answer
    chk_sys_repeat_read: assert property (@(posedge clk_sys) disable iff (!resetn) // [R9]
        io_rd && hit_sys_data && sys_accessed
        |=> io_rdata_valid && io_rdata == ICPP_IGNORED_READ)
        else $error("repeat system read not ignored");

    // [R10] flags independent
    chk_flag_separate: assert property (@(posedge clk_sys) disable iff (!resetn) // [R10]
        (io_wr || io_rd) && (hit_sys_index || hit_sys_data) |=> $stable(cfg_accessed))
        else $error("system activity moved normal flag");

    // [R10] normal activity leaves system flag
    chk_flag_apart_sys: assert property (@(posedge clk_sys) disable iff (!resetn) // [R10]
        (io_wr || io_rd) && (hit_cfg_index || hit_cfg_data) |=> $stable(sys_accessed))
        else $error("normal activity moved system flag");

    // [R11] fast reset is a single pulse
    chk_kbd_reset_pulse: assert property (@(posedge clk_sys) disable iff (!resetn) // [R11]
        io_wr && hit_kbd && !io_wdata[ICPP_KBD_RESET_BIT] |=> fast_reset
        ##1 (!fast_reset || $past(io_wr && hit_kbd && !io_wdata[ICPP_KBD_RESET_BIT])))
        else $error("fast reset pulse wrong");

    // [R11] a20 follows keyboard write
    chk_kbd_a20: assert property (@(posedge clk_sys) disable iff (!resetn) // [R11]
        io_wr && hit_kbd |=> addr_line20_gate == $past(io_wdata[ICPP_KBD_A20_BIT]))
        else $error("address line 20 gate wrong");

    // [R11] a20 kept between writes
    chk_kbd_a20_hold: assert property (@(posedge clk_sys) disable iff (!resetn) // [R11]
        !(io_wr && hit_kbd) |=> $stable(addr_line20_gate))
        else $error("address line 20 gate moved without write");

    // [R11] keyboard port readback
    chk_kbd_readback: assert property (@(posedge clk_sys) disable iff (!resetn) // [R11]
        io_rd && hit_kbd |=> io_rdata_valid && io_rdata == $past(kbd_port))
        else $error("keyboard port read wrong");

    // [R12] index write reopens system window
    chk_sys_index_clear: assert property (@(posedge clk_sys) disable iff (!resetn) // [R12]
        io_wr && hit_sys_index |=> !sys_accessed)
        else $error("system index write left flag set");

    // [R12] any normal data access closes window
    chk_cfg_flag_set: assert property (@(posedge clk_sys) disable iff (!resetn) // [R12]
        (io_wr || io_rd) && hit_cfg_data |=> cfg_accessed)
        else $error("normal data access left flag clear");

    // [R12] one access after index write
    chk_one_shot: assert property (@(posedge clk_sys) disable iff (!resetn) // [R12]
        io_wr && hit_cfg_index ##2 io_rd && hit_cfg_data ##1 !(io_wr && hit_cfg_index)
        ##1 io_rd && hit_cfg_data |=> io_rdata == ICPP_IGNORED_READ)
        else $error("second access after index write not ignored");

    cov_cfg_write: cover property (@(posedge clk_sys) disable iff (!resetn)
        io_wr && hit_cfg_index ##1 io_wr && hit_cfg_data);
    cov_sys_read: cover property (@(posedge clk_sys) disable iff (!resetn)
        io_wr && hit_sys_index ##1 io_rd && hit_sys_data);
    cov_ignored: cover property (@(posedge clk_sys) disable iff (!resetn)
        io_rd && hit_cfg_data && cfg_accessed);
    cov_sys_ignored: cover property (@(posedge clk_sys) disable iff (!resetn)
        io_rd && hit_sys_data && sys_accessed);
    cov_fast_reset: cover property (@(posedge clk_sys) disable iff (!resetn)
        fast_reset);
endmodule : icpp_port_pair
`default_nettype wire

//--- icpp_host_model.sv
// icpp_host_model: host processor issuing i/o port cycles to the port pair
// assumes the bench calls its tasks; lines change at the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module icpp_host_model
    import icpp_pkg::*;
(
    input wire logic clk_sys, // system clock
    output var logic [icpp_pkg::ICPP_AW-1:0] io_addr, // port address
    output var logic io_wr, // write strobe
    output var logic io_rd, // read strobe
    output var logic [icpp_pkg::ICPP_DW-1:0] io_wdata, // write data
    input wire logic [icpp_pkg::ICPP_DW-1:0] io_rdata, // read data
    input wire logic io_rdata_valid // read answer pulse
);
    // ========================================
    // idle bus at time zero
    initial begin
        io_addr = 16'h0000;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end
    // ========================================
    // one-cycle write, released lines show the inverse
    // defined indexes only
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk_sys);
        io_wr = 1'b0;
        io_addr = ~a;
        io_wdata = ~d;
    endtask : wr
    // one-cycle read, bounded wait for the answer
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output bit ok);
        ok = 1'b0;
        d = 8'h00;
        @(negedge clk_sys);
        io_addr = a;
        io_rd = 1'b1;
        for (int i = 0; i < 3 && !ok; i++) begin
            @(negedge clk_sys);
            io_rd = 1'b0;
            io_addr = ~a;
            if (io_rdata_valid === 1'b1) begin
                d = io_rdata;
                ok = 1'b1;
            end
        end
    endtask : rd
endmodule : icpp_host_model
`default_nettype wire

//--- tb_indexed_config_port_pair.sv
// tb_indexed_config_port_pair: self-checking bench for the port pair
// assumes icpp_pkg and icpp_host_model are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
    $display("BAD %0t value mismatch", $time); end end
module tb_indexed_config_port_pair;
    import icpp_pkg::*;
    logic clk_sys = 1'b0; // 50 MHz clock
    logic resetn = 1'b0; // active low reset
    logic [15:0] io_addr; // port address
    logic io_wr, io_rd; // strobes
    logic [7:0] io_wdata, io_rdata; // data
    logic io_rdata_valid, addr_line20_gate, fast_reset; // outputs
    int err_total = 0; // mismatches
    int checks_done = 0; // comparisons
    // ========================================
    // clock, half period 10 ns
    always #10 clk_sys = ~clk_sys;
    icpp_host_model i_host (.clk_sys(clk_sys), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_rdata_valid(io_rdata_valid));
    icpp_port_pair #(.ICPP_DEPTH(256)) i_dut (.clk_sys(clk_sys), .resetn(resetn),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
        .addr_line20_gate(addr_line20_gate), .fast_reset(fast_reset));
    // ========================================
    // verdict and end of run
    task automatic conclude;
        if (err_total == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    // read and compare, a lost answer ends the run
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bit ok;
        i_host.rd(a, d, ok);
        if (!ok) begin
            err_total++;
            conclude();
        end else begin
            `CHK(d, exp)
        end
    endtask : rd_chk
    // defaults after reset
    task automatic t_defaults;
        `CHK(addr_line20_gate, 1'b0)
        `CHK(fast_reset, 1'b0)
        i_host.wr(ICPP_CFG_INDEX_PORT, 8'h05);
        rd_chk(ICPP_CFG_DATA_PORT, ICPP_CFG_DEFAULT);
        rd_chk(ICPP_KBD_DATA_PORT, ICPP_KBD_RESET);
    endtask : t_defaults
    // normal window writes, unmapped write between
    task automatic t_window1;
        i_host.wr(ICPP_CFG_INDEX_PORT, 8'h10);
        i_host.wr(16'h0024, 8'h99);
        i_host.wr(ICPP_CFG_DATA_PORT, 8'hA5);
        i_host.wr(ICPP_CFG_INDEX_PORT, 8'h11);
        i_host.wr(ICPP_CFG_DATA_PORT, 8'hC3);
        i_host.wr(ICPP_CFG_INDEX_PORT, 8'h10);
        rd_chk(ICPP_CFG_DATA_PORT, 8'hA5);
    endtask : t_window1
    // second data access ignored until reindex
    task automatic t_repeat;
        logic [7:0] d;
        bit ok;
        rd_chk(ICPP_CFG_DATA_PORT, ICPP_IGNORED_READ);
        i_host.wr(ICPP_CFG_DATA_PORT, 8'h77);
        i_host.wr(ICPP_CFG_INDEX_PORT, 8'h10);
        rd_chk(ICPP_CFG_DATA_PORT, 8'hA5);
        // write-only index port gives no read answer
        i_host.rd(ICPP_CFG_INDEX_PORT, d, ok);
        `CHK(ok, 1'b0)
    endtask : t_repeat
    // second window with its own index and flag
    task automatic t_window2;
        i_host.wr(ICPP_CFG_INDEX_PORT, 8'h11);
        i_host.wr(ICPP_SYS_INDEX_PORT, 8'h10);
        rd_chk(ICPP_SYS_DATA_PORT, 8'hA5);
        i_host.wr(ICPP_CFG_DATA_PORT, 8'h3C);
        rd_chk(ICPP_SYS_DATA_PORT, ICPP_IGNORED_READ);
        i_host.wr(ICPP_CFG_INDEX_PORT, 8'h11);
        rd_chk(ICPP_CFG_DATA_PORT, 8'h3C);
    endtask : t_window2
    // keyboard data port gate and fast reset
    task automatic t_kbd;
        i_host.wr(ICPP_KBD_DATA_PORT, 8'h03);
        `CHK(addr_line20_gate, 1'b1)
        `CHK(fast_reset, 1'b0)
        i_host.wr(ICPP_KBD_DATA_PORT, 8'h00);
        `CHK(fast_reset, 1'b1)
        @(negedge clk_sys);
        `CHK(fast_reset, 1'b0)
        `CHK(addr_line20_gate, 1'b0)
        rd_chk(ICPP_KBD_DATA_PORT, 8'h00);
    endtask : t_kbd
    // mid-run reset restores defaults
    task automatic t_rereset;
        @(negedge clk_sys);
        resetn = 1'b0;
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        i_host.wr(ICPP_CFG_INDEX_PORT, 8'h10);
        rd_chk(ICPP_CFG_DATA_PORT, ICPP_CFG_DEFAULT);
        rd_chk(ICPP_KBD_DATA_PORT, ICPP_KBD_RESET);
    endtask : t_rereset
    // ========================================
    // main sequence
    initial begin
        repeat (4) @(negedge clk_sys);
        resetn = 1'b1;
        t_defaults();
        t_window1();
        t_repeat();
        t_window2();
        t_kbd();
        t_rereset();
        conclude();
    end
endmodule : tb_indexed_config_port_pair
`default_nettype wire
